// ==== core/cms_pkg.sv ====
// Package of the clock mode sequencer: modes, reset values and divider codes.
// Assumes a single 25 MHz clock domain and a synchronous active-low reset.
`default_nettype none
package cms_pkg;
    // ****************************************************************
    // Modes
    // ****************************************************************
    typedef enum logic [7:0] {
        CMS_HIGH_MID = 8'h01,
        CMS_LOW_SPD = 8'h02,
        CMS_LOW_PWR = 8'h04,
        CMS_PLL = 8'h08,
        CMS_OCO = 8'h10,
        CMS_OCO_LP = 8'h20,
        CMS_STOP = 8'h40,
        CMS_WAIT = 8'h80
    } cms_mode_e;
    // ****************************************************************
    // Clock source codes and divider codes
    // ****************************************************************
    localparam logic [1:0] CMS_SRC_MAIN = 2'h0;
    localparam logic [1:0] CMS_SRC_SUB = 2'h1;
    localparam logic [1:0] CMS_SRC_OCO = 2'h2;
    localparam logic [1:0] CMS_SRC_PLL = 2'h3;
    localparam logic [4:0] CMS_DIV_1 = 5'h01;
    localparam logic [4:0] CMS_DIV_2 = 5'h02;
    localparam logic [4:0] CMS_DIV_4 = 5'h04;
    localparam logic [4:0] CMS_DIV_8 = 5'h08;
    localparam logic [4:0] CMS_DIV_16 = 5'h10;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic CMS_RST_DIV8 = 1'h1;
    localparam logic [1:0] CMS_RST_DIV_FIELD = 2'h0;
    localparam logic CMS_RST_SUB_EN = 1'h0;
    localparam logic CMS_RST_MAIN_STOP = 1'h0;
    localparam logic CMS_RST_SUB_SEL = 1'h0;
    localparam logic CMS_RST_PLL = 1'h0;
    localparam logic CMS_RST_OCO_SEL = 1'h0;
    localparam logic CMS_RST_DETECT = 1'h0;
    localparam logic CMS_RST_WAIT_PSTOP = 1'h0;
    localparam logic CMS_RST_HIGH_DRIVE = 1'h1;
    localparam logic CMS_RST_LOCK = 1'h0;
endpackage : cms_pkg
`default_nettype wire

// ==== core/cms_div_if.sv ====
// Interface carrying the divider select between the sequencer and its decoder.
// Assumes both ends sit in the same clock domain.
`default_nettype none
interface cms_div_if;
    logic div8_select_bit;
    logic [1:0] cpu_div_field;
    logic [4:0] divide_ratio;
    modport ctrl (output div8_select_bit, output cpu_div_field, input divide_ratio);
    modport dec (input div8_select_bit, input cpu_div_field, output divide_ratio);
endinterface : cms_div_if
`default_nettype wire

// ==== core/cms_div_decode.sv ====
// Decoder of the CPU clock divide ratio from the divider control bits.
// Assumes the bits come from registers in the sequencer.
`default_nettype none
module cms_div_decode
    import cms_pkg::*;
(
    cms_div_if.dec div
);
    // ****************************************************************
    // Ratio decode
    // ****************************************************************
    wire logic [4:0] field_ratio;
    assign field_ratio = (div.cpu_div_field == 2'h0) ? CMS_DIV_1 :
                         (div.cpu_div_field == 2'h1) ? CMS_DIV_2 :
                         (div.cpu_div_field == 2'h2) ? CMS_DIV_4 : CMS_DIV_16;
    assign div.divide_ratio = div.div8_select_bit ? CMS_DIV_8 : field_ratio;
endmodule : cms_div_decode
`default_nettype wire

// ==== core/cms_clock_mode_sequencer.sv ====
// Clock mode sequencer: control bits, lock, stop and wait entry and exit.
// Assumes software writes arrive as one-cycle strobes with data on plain ports.
//
// Notes on behaviour
// - Stop mode ends on reset, non-maskable, low voltage or enabled peripheral interrupt.
// - Peripheral wake starts the service routine once the CPU clock returns.
// - After stop wake the CPU runs on sub clock, or main or oscillator by 8.
// - Leaving stop sets the divide-by-8 select bit.
// - PLL mode is entered and left only through high-speed mode.
// - Main-clock stop from low-speed enters low power and sets divide-by-8.
// - Interrupts never return to PLL mode; PLL mode never enters stop or wait.
// - Divider field gives 1, 2, 4 or 16; divide-by-8 bit overrides with 8.
// - Enable, stop and select bits turn sub and main clocks on and off.
// - Stop request enters stop unless the lock bit is set, wait instruction enters wait, except in PLL mode.
// - Low-speed keeps the oscillator usable, PLL mode keeps the sub clock usable.
// - Lock bit blocks writes to the sub-clock select, stop, PLL and detection bits, but not to the on-chip oscillator select.
// - Divider fields and sub-clock enable change freely within a mode.
// - Stop request also sets divide-by-8 and main oscillator high drive.
`default_nettype none
module cms_clock_mode_sequencer
    import cms_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ctrl_write,
    input wire logic wr_div8_select_bit,
    input wire logic [1:0] wr_cpu_div_field,
    input wire logic wr_sub_clock_enable,
    input wire logic wr_main_clock_stop,
    input wire logic wr_sub_clock_cpu_select,
    input wire logic wr_onchip_osc_select,
    input wire logic wr_wait_periph_clock_stop,
    input wire logic wr_main_osc_high_drive,
    input wire logic wr_stop_request_bit,
    input wire logic pll_write,
    input wire logic wr_pll_enable,
    input wire logic wr_pll_cpu_source,
    input wire logic detect_write,
    input wire logic wr_osc_stop_detect_enable,
    input wire logic lock_write,
    input wire logic protect_write_enable,
    input wire logic wr_clock_change_lock,
    input wire logic wait_instr,
    input wire logic sub_clock_running,
    input wire logic nmi_irq,
    input wire logic low_voltage_irq,
    input wire logic periph_irq,
    output logic div8_select_bit,
    output logic [1:0] cpu_div_field,
    output logic [4:0] divide_ratio,
    output logic sub_clock_enable,
    output logic main_clock_stop,
    output logic sub_clock_cpu_select,
    output logic onchip_osc_select,
    output logic wait_periph_clock_stop,
    output logic main_osc_high_drive,
    output logic pll_enable,
    output logic pll_cpu_source,
    output logic osc_stop_detect_enable,
    output logic clock_change_lock,
    output logic [1:0] cpu_clock_source,
    output logic cpu_clock_on,
    output logic irq_service_start,
    output cms_mode_e mode
);
    // ****************************************************************
    // Mode decode and transition conditions
    // ****************************************************************
    cms_mode_e next_mode;
    logic in_sleep;
    logic run_mode;
    logic wake;
    logic stop_req;
    logic wait_req;
    logic pll_entry;
    logic pll_exit;
    logic lowpwr_entry;
    logic lowpwr_exit;
    logic free_write;
    logic guarded_write;
    assign in_sleep = (mode == CMS_STOP) || (mode == CMS_WAIT);
    assign run_mode = !in_sleep && (mode != CMS_PLL);
    assign wake = nmi_irq || low_voltage_irq || periph_irq;
    assign free_write = ctrl_write && !in_sleep;
    assign guarded_write = free_write && !clock_change_lock;
    assign stop_req = guarded_write && wr_stop_request_bit && run_mode;
    assign wait_req = wait_instr && run_mode;
    assign pll_entry = pll_write && !clock_change_lock && (mode == CMS_HIGH_MID)
                       && wr_pll_enable && wr_pll_cpu_source;
    assign pll_exit = pll_write && !clock_change_lock && (mode == CMS_PLL)
                      && !wr_pll_enable && !wr_pll_cpu_source;
    assign lowpwr_entry = guarded_write && wr_main_clock_stop && !main_clock_stop
                          && (mode == CMS_LOW_SPD || mode == CMS_OCO);
    assign lowpwr_exit = guarded_write && !wr_main_clock_stop && main_clock_stop;
    // ****************************************************************
    // Mode sequencing
    // ****************************************************************
    cms_mode_e resume_mode;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            resume_mode <= CMS_HIGH_MID;
        else if (stop_req || wait_req)
            resume_mode <= mode;
    end
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            CMS_STOP, CMS_WAIT:
            begin
                if (wake)
                    next_mode = resume_mode;
            end
            CMS_PLL:
            begin
                if (pll_exit)
                    next_mode = CMS_HIGH_MID;
            end
            CMS_HIGH_MID:
            begin
                if (stop_req)
                    next_mode = CMS_STOP;
                else if (wait_req)
                    next_mode = CMS_WAIT;
                else if (pll_entry)
                    next_mode = CMS_PLL;
                else if (guarded_write && wr_sub_clock_cpu_select)
                    next_mode = CMS_LOW_SPD;
                else if (free_write && wr_onchip_osc_select)
                    next_mode = CMS_OCO;
            end
            CMS_LOW_SPD, CMS_OCO:
            begin
                if (stop_req)
                    next_mode = CMS_STOP;
                else if (wait_req)
                    next_mode = CMS_WAIT;
                else if (lowpwr_entry)
                    next_mode = (mode == CMS_LOW_SPD) ? CMS_LOW_PWR : CMS_OCO_LP;
                else if (mode == CMS_LOW_SPD && guarded_write && !wr_sub_clock_cpu_select)
                    next_mode = CMS_HIGH_MID;
                else if (mode == CMS_OCO && free_write && !wr_onchip_osc_select)
                    next_mode = CMS_HIGH_MID;
            end
            CMS_LOW_PWR, CMS_OCO_LP:
            begin
                if (stop_req)
                    next_mode = CMS_STOP;
                else if (wait_req)
                    next_mode = CMS_WAIT;
                else if (lowpwr_exit)
                    next_mode = (mode == CMS_LOW_PWR) ? CMS_LOW_SPD : CMS_OCO;
            end
            default:
                next_mode = CMS_HIGH_MID;
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            mode <= CMS_HIGH_MID;
        else
            mode <= next_mode;
    end
    // ****************************************************************
    // Control bits
    // ****************************************************************
    logic stop_exit;
    assign stop_exit = (mode == CMS_STOP) && wake;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            div8_select_bit <= CMS_RST_DIV8;
            cpu_div_field <= CMS_RST_DIV_FIELD;
            sub_clock_enable <= CMS_RST_SUB_EN;
            onchip_osc_select <= CMS_RST_OCO_SEL;
            main_osc_high_drive <= CMS_RST_HIGH_DRIVE;
        end
        else
        begin
            if (stop_exit || stop_req || lowpwr_entry)
                div8_select_bit <= 1'h1;
            else if (free_write)
                div8_select_bit <= wr_div8_select_bit;
            if (stop_req)
                main_osc_high_drive <= 1'h1;
            else if (free_write)
                main_osc_high_drive <= wr_main_osc_high_drive;
            if (free_write)
            begin
                cpu_div_field <= wr_cpu_div_field;
                sub_clock_enable <= wr_sub_clock_enable;
                if (mode != CMS_PLL)
                    onchip_osc_select <= wr_onchip_osc_select;
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            main_clock_stop <= CMS_RST_MAIN_STOP;
            sub_clock_cpu_select <= CMS_RST_SUB_SEL;
            wait_periph_clock_stop <= CMS_RST_WAIT_PSTOP;
            osc_stop_detect_enable <= CMS_RST_DETECT;
            pll_enable <= CMS_RST_PLL;
            pll_cpu_source <= CMS_RST_PLL;
            clock_change_lock <= CMS_RST_LOCK;
        end
        else
        begin
            if (guarded_write)
            begin
                main_clock_stop <= wr_main_clock_stop;
                sub_clock_cpu_select <= wr_sub_clock_cpu_select;
                wait_periph_clock_stop <= wr_wait_periph_clock_stop;
            end
            if (detect_write && !clock_change_lock)
                osc_stop_detect_enable <= wr_osc_stop_detect_enable;
            if (pll_entry || pll_exit)
            begin
                pll_enable <= pll_entry;
                pll_cpu_source <= pll_entry;
            end
            else if (pll_write && !clock_change_lock && mode != CMS_PLL)
                pll_enable <= wr_pll_enable;
            if (lock_write && protect_write_enable)
                clock_change_lock <= wr_clock_change_lock;
        end
    end
    // ****************************************************************
    // Clock source, divider and service start
    // ****************************************************************
    cms_div_if div_bus ();
    assign div_bus.div8_select_bit = div8_select_bit;
    assign div_bus.cpu_div_field = cpu_div_field;
    cms_div_decode u_div (.div(div_bus));
    assign divide_ratio = div_bus.divide_ratio;
    assign cpu_clock_source = sub_clock_cpu_select ? CMS_SRC_SUB :
                              pll_cpu_source ? CMS_SRC_PLL :
                              onchip_osc_select ? CMS_SRC_OCO : CMS_SRC_MAIN;
    assign cpu_clock_on = !in_sleep;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            irq_service_start <= 1'h0;
        else
            irq_service_start <= in_sleep && wake;
    end
    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_STOP_EXIT_DIV8: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == CMS_STOP && wake) |=> div8_select_bit && mode != CMS_STOP)
        else $error("Stop exit did not force divide by 8.");
    AST_STOP_ENTRY_BITS: assert property (@(posedge clk) disable iff (!reset_n)
        stop_req |=> mode == CMS_STOP && div8_select_bit && main_osc_high_drive)
        else $error("Stop entry bits not set.");
    AST_NO_PLL_RETURN: assert property (@(posedge clk) disable iff (!reset_n)
        in_sleep |=> mode != CMS_PLL)
        else $error("Sleep returned to PLL mode.");
    AST_PLL_NO_SLEEP: assert property (@(posedge clk) disable iff (!reset_n)
        mode == CMS_PLL |=> !in_sleep)
        else $error("PLL mode entered sleep.");
    AST_PLL_VIA_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
        (mode != CMS_PLL ##1 mode == CMS_PLL) |-> $past(mode) == CMS_HIGH_MID
        && pll_enable && pll_cpu_source)
        else $error("PLL entered from wrong mode.");
    AST_LOCK_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
        clock_change_lock && !lock_write |=> $stable(main_clock_stop)
        && $stable(sub_clock_cpu_select) && $stable(pll_enable))
        else $error("Locked bit changed.");
    AST_LOWPWR_ENTRY: assert property (@(posedge clk) disable iff (!reset_n)
        (lowpwr_entry && mode == CMS_LOW_SPD) |=> mode == CMS_LOW_PWR && div8_select_bit)
        else $error("Low power entry wrong.");
    AST_DIV_DECODE: assert property (@(posedge clk) disable iff (!reset_n)
        !div8_select_bit && cpu_div_field == 2'h3 |-> divide_ratio == CMS_DIV_16)
        else $error("Divide by 16 decode wrong.");
    AST_SERVICE_START: assert property (@(posedge clk) disable iff (!reset_n)
        (in_sleep && periph_irq) |=> irq_service_start && cpu_clock_on)
        else $error("Service start missing after wake.");
endmodule : cms_clock_mode_sequencer
`default_nettype wire

// ==== verification/clock_mode_sequencer_bench.sv ====
// Self-checking bench of the clock mode sequencer; drives its plain ports and notes expectations.
// Assumes cms_pkg and cms_clock_mode_sequencer are compiled before this file.
`default_nettype none
module clock_mode_sequencer_bench
    import cms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Signals and expectation notes
    // ****************************************************************
    typedef struct packed {
        cms_mode_e mode;
        logic div8, sub_en, mstop, subsel, oco, wps, hd, pll_en, pll_src, det, lock, irq, on;
        logic [1:0] fld;
        logic [1:0] src;
        logic [4:0] ratio;
    } cms_note_s;
    localparam logic [2:0] SK_PER = 3'h0, SK_LV = 3'h1, SK_NMI = 3'h2, SK_WAIT = 3'h3;
    localparam logic [2:0] SK_LOCK = 3'h4, SK_DET = 3'h5, SK_PLL = 3'h6;
    logic clk, reset_n, ctrl_write, wr_div8_select_bit, wr_sub_clock_enable, wr_main_clock_stop;
    logic wr_sub_clock_cpu_select, wr_onchip_osc_select, wr_wait_periph_clock_stop;
    logic wr_main_osc_high_drive, wr_stop_request_bit, pll_write, wr_pll_enable, wr_pll_cpu_source;
    logic detect_write, wr_osc_stop_detect_enable, lock_write, protect_write_enable;
    logic wr_clock_change_lock, wait_instr, sub_clock_running, nmi_irq, low_voltage_irq, periph_irq;
    logic [1:0] wr_cpu_div_field, cpu_div_field, cpu_clock_source;
    logic [4:0] divide_ratio;
    logic div8_select_bit, sub_clock_enable, main_clock_stop, sub_clock_cpu_select;
    logic onchip_osc_select, wait_periph_clock_stop, main_osc_high_drive, pll_enable;
    logic pll_cpu_source, osc_stop_detect_enable, clock_change_lock, cpu_clock_on, irq_service_start;
    cms_mode_e mode;
    cms_note_s e, w, n;
    cms_note_s q[$];
    int num_errors = 0;
    int cmp_count = 0;

    cms_clock_mode_sequencer i_cms_clock_mode_sequencer (
        .clk(clk), .reset_n(reset_n), .ctrl_write(ctrl_write),
        .wr_div8_select_bit(wr_div8_select_bit), .wr_cpu_div_field(wr_cpu_div_field),
        .wr_sub_clock_enable(wr_sub_clock_enable), .wr_main_clock_stop(wr_main_clock_stop),
        .wr_sub_clock_cpu_select(wr_sub_clock_cpu_select),
        .wr_onchip_osc_select(wr_onchip_osc_select),
        .wr_wait_periph_clock_stop(wr_wait_periph_clock_stop),
        .wr_main_osc_high_drive(wr_main_osc_high_drive), .wr_stop_request_bit(wr_stop_request_bit),
        .pll_write(pll_write), .wr_pll_enable(wr_pll_enable), .wr_pll_cpu_source(wr_pll_cpu_source),
        .detect_write(detect_write), .wr_osc_stop_detect_enable(wr_osc_stop_detect_enable),
        .lock_write(lock_write), .protect_write_enable(protect_write_enable),
        .wr_clock_change_lock(wr_clock_change_lock), .wait_instr(wait_instr),
        .sub_clock_running(sub_clock_running), .nmi_irq(nmi_irq),
        .low_voltage_irq(low_voltage_irq), .periph_irq(periph_irq),
        .div8_select_bit(div8_select_bit), .cpu_div_field(cpu_div_field),
        .divide_ratio(divide_ratio), .sub_clock_enable(sub_clock_enable),
        .main_clock_stop(main_clock_stop), .sub_clock_cpu_select(sub_clock_cpu_select),
        .onchip_osc_select(onchip_osc_select), .wait_periph_clock_stop(wait_periph_clock_stop),
        .main_osc_high_drive(main_osc_high_drive), .pll_enable(pll_enable),
        .pll_cpu_source(pll_cpu_source), .osc_stop_detect_enable(osc_stop_detect_enable),
        .clock_change_lock(clock_change_lock), .cpu_clock_source(cpu_clock_source),
        .cpu_clock_on(cpu_clock_on), .irq_service_start(irq_service_start), .mode(mode)
    );
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp_v);
        cmp_count++;
        if (seen !== exp_v)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp_v);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic note();
        e.ratio = e.div8 ? CMS_DIV_8 : e.fld == 2'h0 ? CMS_DIV_1 : e.fld == 2'h1 ? CMS_DIV_2 :
            e.fld == 2'h2 ? CMS_DIV_4 : CMS_DIV_16;
        e.src = e.subsel ? CMS_SRC_SUB : e.oco ? CMS_SRC_OCO : e.pll_src ? CMS_SRC_PLL : CMS_SRC_MAIN;
        e.on = !(e.mode inside {CMS_STOP, CMS_WAIT});
        q.push_back(e);
        e.irq = 1'b0;
    endtask : note

    task automatic ctrl_wr(input logic stop);
        @(negedge clk);
        ctrl_write = 1'b1;
        wr_div8_select_bit = w.div8;
        wr_cpu_div_field = w.fld;
        wr_sub_clock_enable = w.sub_en;
        wr_main_clock_stop = w.mstop;
        wr_sub_clock_cpu_select = w.subsel;
        wr_onchip_osc_select = w.oco;
        wr_wait_periph_clock_stop = w.wps;
        wr_main_osc_high_drive = w.hd;
        wr_stop_request_bit = stop;
        @(negedge clk);
        ctrl_write = 1'b0;
        wr_stop_request_bit = 1'b0;
    endtask : ctrl_wr

    task automatic strobe(input logic [2:0] k, input logic a, input logic b);
        @(negedge clk);
        wr_pll_enable = a;
        wr_pll_cpu_source = b;
        wr_osc_stop_detect_enable = a;
        protect_write_enable = a;
        wr_clock_change_lock = b;
        {pll_write, detect_write, lock_write, wait_instr, nmi_irq, low_voltage_irq, periph_irq} =
            7'h01 << k;
        @(negedge clk);
        {pll_write, detect_write, lock_write, wait_instr, nmi_irq, low_voltage_irq, periph_irq} = '0;
    endtask : strobe

    task automatic do_reset();
        @(negedge clk);
        reset_n = 1'b0;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        e = '0;
        e.mode = CMS_HIGH_MID;
        e.div8 = CMS_RST_DIV8;
        e.hd = CMS_RST_HIGH_DRIVE;
        e.fld = CMS_RST_DIV_FIELD;
        note();
    endtask : do_reset

    task automatic sleep_stop();
        w = e;
        w.div8 = 1'b0;
        w.hd = 1'b0;
        ctrl_wr(1'b1);
        e = w;
        e.mode = CMS_STOP;
        e.div8 = 1'b1;
        e.hd = 1'b1;
        note();
    endtask : sleep_stop
    // ****************************************************************
    // Clock, monitor and run limit
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(negedge clk)
    begin
        #5;
        while (q.size() > 0)
        begin
            n = q.pop_front();
            check(16'(mode), 16'(n.mode));
            check(16'(divide_ratio), 16'(n.ratio));
            check(16'(cpu_clock_source), 16'(n.src));
            check(16'({div8_select_bit, main_osc_high_drive}), 16'({n.div8, n.hd}));
            check(16'({cpu_div_field, sub_clock_enable}), 16'({n.fld, n.sub_en}));
            check(16'({main_clock_stop, sub_clock_cpu_select, onchip_osc_select}),
                16'({n.mstop, n.subsel, n.oco}));
            check(16'({wait_periph_clock_stop, osc_stop_detect_enable, clock_change_lock}),
                16'({n.wps, n.det, n.lock}));
            check(16'({pll_enable, pll_cpu_source}), 16'({n.pll_en, n.pll_src}));
            check(16'({cpu_clock_on, irq_service_start}), 16'({n.on, n.irq}));
        end
    end

    initial
    begin
        repeat (6000) @(posedge clk);
        num_errors++;
        $display("CHECK FAILED t=%0t run limit reached", $time);
        results();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {ctrl_write, wr_div8_select_bit, wr_cpu_div_field, wr_sub_clock_enable} = '0;
        {wr_main_clock_stop, wr_sub_clock_cpu_select, wr_onchip_osc_select} = '0;
        {wr_wait_periph_clock_stop, wr_main_osc_high_drive, wr_stop_request_bit} = '0;
        {pll_write, wr_pll_enable, wr_pll_cpu_source, detect_write, wr_osc_stop_detect_enable} = '0;
        {lock_write, protect_write_enable, wr_clock_change_lock, wait_instr} = '0;
        {nmi_irq, low_voltage_irq, periph_irq, reset_n} = '0;
        sub_clock_running = 1'b1;
        void'($urandom(24));
        do_reset();
        for (int i = 0; i < 5; i++)
        begin
            w = e;
            w.div8 = (i == 4);
            w.fld = i[1:0];
            w.sub_en = 1'($urandom);
            ctrl_wr(1'b0);
            e = w;
            note();
        end
        w = e;
        w.sub_en = 1'b1;
        w.subsel = 1'b1;
        ctrl_wr(1'b0);
        e = w;
        e.mode = CMS_LOW_SPD;
        note();
        strobe(SK_PLL, 1'b1, 1'b1);
        e.pll_en = 1'b1;
        note();
        w = e;
        w.mstop = 1'b1;
        w.div8 = 1'b0;
        ctrl_wr(1'b0);
        e.mstop = 1'b1;
        e.mode = CMS_LOW_PWR;
        note();
        w = e;
        w.mstop = 1'b0;
        ctrl_wr(1'b0);
        e = w;
        e.mode = CMS_LOW_SPD;
        note();
        sleep_stop();
        strobe(SK_NMI, 1'b0, 1'b0);
        e.mode = CMS_LOW_SPD;
        e.irq = 1'b1;
        note();
        w = e;
        w.subsel = 1'b0;
        ctrl_wr(1'b0);
        e = w;
        e.mode = CMS_HIGH_MID;
        note();
        w.oco = 1'b1;
        w.div8 = 1'b0;
        w.fld = 2'($urandom);
        ctrl_wr(1'b0);
        e = w;
        e.mode = CMS_OCO;
        note();
        w.mstop = 1'b1;
        ctrl_wr(1'b0);
        e = w;
        e.div8 = 1'b1;
        e.mode = CMS_OCO_LP;
        note();
        w = e;
        w.mstop = 1'b0;
        ctrl_wr(1'b0);
        e = w;
        e.mode = CMS_OCO;
        note();
        sleep_stop();
        strobe(SK_LV, 1'b0, 1'b0);
        e.mode = CMS_OCO;
        e.irq = 1'b1;
        note();
        w = e;
        w.oco = 1'b0;
        ctrl_wr(1'b0);
        e = w;
        e.mode = CMS_HIGH_MID;
        note();
        sleep_stop();
        w.subsel = 1'b1;
        w.fld = ~e.fld;
        ctrl_wr(1'b0);
        note();
        strobe(SK_PER, 1'b0, 1'b0);
        e.mode = CMS_HIGH_MID;
        e.irq = 1'b1;
        note();
        w = e;
        w.div8 = 1'b0;
        w.fld = 2'h0;
        ctrl_wr(1'b0);
        e = w;
        note();
        strobe(SK_WAIT, 1'b0, 1'b0);
        e.mode = CMS_WAIT;
        note();
        strobe(SK_NMI, 1'b0, 1'b0);
        e.mode = CMS_HIGH_MID;
        e.irq = 1'b1;
        note();
        strobe(SK_PLL, 1'b1, 1'b1);
        {e.pll_en, e.pll_src} = 2'b11;
        e.mode = CMS_PLL;
        note();
        strobe(SK_WAIT, 1'b0, 1'b0);
        w = e;
        ctrl_wr(1'b1);
        note();
        strobe(SK_PLL, 1'b0, 1'b0);
        {e.pll_en, e.pll_src} = 2'b00;
        e.mode = CMS_HIGH_MID;
        note();
        strobe(SK_LOCK, 1'b0, 1'b1);
        note();
        strobe(SK_LOCK, 1'b1, 1'b1);
        e.lock = 1'b1;
        note();
        w = e;
        {w.fld, w.sub_en, w.mstop, w.subsel, w.wps} = {e.fld + 2'h1, ~e.sub_en, 3'b111};
        ctrl_wr(1'b1);
        {e.fld, e.sub_en} = {w.fld, w.sub_en};
        note();
        strobe(SK_PLL, 1'b1, 1'b1);
        strobe(SK_DET, 1'b1, 1'b0);
        note();
        strobe(SK_LOCK, 1'b1, 1'b0);
        strobe(SK_DET, 1'b1, 1'b0);
        {e.lock, e.det} = 2'b01;
        note();
        w = e;
        w.wps = 1'b1;
        ctrl_wr(1'b0);
        e = w;
        note();
        strobe(SK_DET, 1'b0, 1'b0);
        e.det = 1'b0;
        note();
        sleep_stop();
        do_reset();
        repeat (3) @(negedge clk);
        results();
    end
endmodule : clock_mode_sequencer_bench
`default_nettype wire
